// [rtl/tcwg_pkg.sv]
// constants shared by the timer waveform generator
package tcwg_pkg;
  // ==========================================
  // register map
  localparam logic [5:0] OFF_CMD   = 6'h00;  // channel_command
  localparam logic [5:0] OFF_CFG   = 6'h04;  // channel_config
  localparam logic [5:0] OFF_CNT   = 6'h10;  // count_value
  localparam logic [5:0] OFF_MA    = 6'h14;  // match_a
  localparam logic [5:0] OFF_MB    = 6'h18;  // match_b
  localparam logic [5:0] OFF_LIM   = 6'h1c;  // limit_value
  localparam logic [5:0] OFF_FLG   = 6'h20;  // channel_flags
  localparam logic [5:0] OFF_IEN   = 6'h24;  // irq_enable_set
  localparam logic [5:0] OFF_IDIS  = 6'h28;  // irq_enable_clear
  localparam logic [5:0] OFF_IMASK = 6'h2c;  // irq_mask_view
  localparam logic [7:0] OFF_BCMD  = 8'hc0;  // block_command
  localparam logic [7:0] OFF_BCFG  = 8'hc4;  // block_config
  localparam logic [1:0] BLK_WIN   = 2'h3;   // window index of block regs
  // ==========================================
  // channel_config fields
  localparam int CFG_CLK_LSB  = 0;   // counter clock select, 3 bits
  localparam int CFG_INV      = 3;   // count on falling edge
  localparam int CFG_GATE_LSB = 4;   // gate clock by chained line
  localparam int CFG_LSTOP    = 6;   // limit_stop
  localparam int CFG_LDIS     = 7;   // limit_disable
  localparam int CFG_EDGE_LSB = 8;   // event_edge
  localparam int CFG_SRC_LSB  = 10;  // event_source
  localparam int CFG_ETRG     = 12;  // event_trigger_en
  localparam int CFG_PROF_LSB = 13;  // count_profile
  localparam int CFG_GEN      = 15;  // generation mode
  localparam int CFG_A_MA     = 16;  // line a action on match a
  localparam int CFG_A_LIM    = 18;  // line a action on limit
  localparam int CFG_A_EVT    = 20;  // line a action on event
  localparam int CFG_A_SW     = 22;  // line a action on soft trigger
  localparam int CFG_B_MB     = 24;  // line b action on match b
  localparam int CFG_B_LIM    = 26;  // line b action on limit
  localparam int CFG_B_EVT    = 28;  // line b action on event
  localparam int CFG_B_SW     = 30;  // line b action on soft trigger
  // ==========================================
  // command, flag and action codes
  localparam int CMD_ON     = 0;   // count_clock_on
  localparam int CMD_OFF    = 1;   // count_clock_off
  localparam int CMD_SOFT   = 2;   // soft_trigger
  localparam int BCMD_SYNC  = 0;   // all-channel trigger
  localparam int FLG_WRAP   = 0;   // wrap_flag
  localparam int FLG_CLKON  = 16;  // counter clock enabled
  localparam int MASK_W     = 8;   // irq mask width
  localparam int BCFG_W     = 6;   // block_config width
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_CLR = 2'h2;
  localparam logic [1:0] ACT_TOG = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [15:0] CNT_TOP = 16'hffff;  // free-running top
  // ==========================================
  // internal clock dividers, log2 of pclk division
  localparam int PRE_W = 10;
  localparam int DIV_LOG2 [5] = '{1, 3, 5, 7, 10};
endpackage

// [rtl/tcwg_top.sv]
// three-channel 16-bit timer, waveform generation with apb registers
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module tcwg_top #(
  parameter int ADDR_W = 8  // apb address width decoded
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [2:0]        ext_clock_pin,
  input  wire logic [2:0]        line_a_in,
  output logic      [2:0]        line_a_out,
  output logic      [2:0]        line_a_oe_n,
  input  wire logic [2:0]        line_b_in,
  output logic      [2:0]        line_b_out,
  output logic      [2:0]        line_b_oe_n
);

  // ==========================================
  // state
  typedef struct packed {
    logic [2:0][31:0]              cfg;       // channel_config
    logic [2:0][15:0]              cnt;       // count_value
    logic [2:0][15:0]              ra;        // match_a
    logic [2:0][15:0]              rb;        // match_b
    logic [2:0][15:0]              rc;        // limit_value
    logic [2:0][tcwg_pkg::MASK_W-1:0] imask;  // irq mask
    logic [2:0]                    dn;        // counting down
    logic [2:0]                    clk_en;    // counter clock enabled
    logic [2:0]                    clk_run;   // counter clock started
    logic [2:0]                    trig_pend; // trigger awaiting edge
    logic [2:0]                    sw_pend;   // soft trigger awaiting edge
    logic [2:0]                    evt_pend;  // event awaiting edge
    logic [2:0]                    wrap;      // wrap_flag
    logic [2:0]                    line_a;    // line a level
    logic [2:0]                    line_b;    // line b level
    logic [2:0]                    xc_prev;   // chained clocks, last cycle
    logic [2:0]                    evt_prev;  // event source, last cycle
    logic [tcwg_pkg::BCFG_W-1:0]   bcfg;      // block_config
    logic [8:0]                    s1;        // pin sync stage 1
    logic [8:0]                    s2;        // pin sync stage 2
    logic [8:0]                    s3;        // pin sync stage 3
    logic [8:0]                    pin;       // filtered pin levels
    logic [tcwg_pkg::PRE_W-1:0]    pre;       // internal clock prescaler
    logic [31:0]                   rdata;     // apb read data
  } tcwg_state_s;

  tcwg_state_s s_q;  // registered state
  tcwg_state_s s_d;  // next state

  logic [4:0] pre_tick;  // internal clock enables
  logic [2:0] xc;        // chained_clock_0..2
  logic [2:0] tick;      // counter clock edge per channel
  logic [2:0] evt_src;   // selected event source level
  logic [2:0] evt_hit;   // detected external event
  logic [2:0] line_a_v;  // line a as seen for chaining
  logic       wr;        // apb write access
  logic       rd;        // apb read access

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;

  // ==========================================
  // prescaler enables, one pulse every 2^n cycles
  genvar k;
  generate
    for (k = 0; k < 5; k++) begin : g_pre
      assign pre_tick[k] = &s_q.pre[tcwg_pkg::DIV_LOG2[k]-1:0];
    end
  endgenerate

  // ==========================================
  // per-channel clocking and event detection
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_ch
      localparam int LO = (i == 0) ? 1 : 0;  // lower other channel
      localparam int HI = (i == 2) ? 1 : 2;  // higher other channel
      logic [31:0] cfg;   // this channel's config
      logic [1:0]  csel;  // chain select field
      logic [2:0]  ksel;  // counter clock select
      logic [1:0]  gsel;  // gate select
      logic [1:0]  esrc;  // event_source
      logic [1:0]  edg;   // event_edge
      logic        xl;    // selected chained clock, inverted if asked
      logic        xp;    // same, last cycle
      logic        gate;  // gating level
      logic        rise;  // event source rising
      logic        fall;  // event source falling
      assign cfg  = s_q.cfg[i];
      assign csel = s_q.bcfg[2*i +: 2];
      assign ksel = cfg[tcwg_pkg::CFG_CLK_LSB +: 3];
      assign gsel = cfg[tcwg_pkg::CFG_GATE_LSB +: 2];
      assign esrc = cfg[tcwg_pkg::CFG_SRC_LSB +: 2];
      assign edg  = cfg[tcwg_pkg::CFG_EDGE_LSB +: 2];
      // line a of a capture-mode channel is an input
      assign line_a_v[i] = s_q.cfg[i][tcwg_pkg::CFG_GEN] ? s_q.line_a[i] : s_q.pin[3+i];
      // chained clock source select
      always_comb begin
        unique case (csel)
          2'h0:    xc[i] = s_q.pin[i];
          2'h1:    xc[i] = 1'b0;
          2'h2:    xc[i] = line_a_v[LO];
          2'h3:    xc[i] = line_a_v[HI];
        endcase
      end
      // chained clock edge with optional inversion
      assign xl   = (ksel >= 3'h5) ? (xc[ksel[1:0]-2'h1] ^ cfg[tcwg_pkg::CFG_INV]) : 1'b0;
      assign xp   = (ksel >= 3'h5) ? (s_q.xc_prev[ksel[1:0]-2'h1] ^ cfg[tcwg_pkg::CFG_INV]) : 1'b0;
      assign gate = (gsel == 2'h0) ? 1'b1 : xc[gsel-2'h1];
      // counting edge only while enabled and started
      assign tick[i] = s_q.clk_en[i] & s_q.clk_run[i] & gate &
                       ((ksel < 3'h5) ? pre_tick[ksel] : (xl & ~xp));
      // event source select
      assign evt_src[i] = (esrc == 2'h0) ? s_q.pin[6+i] : xc[esrc-2'h1];
      assign rise = evt_src[i] & ~s_q.evt_prev[i];
      assign fall = ~evt_src[i] & s_q.evt_prev[i];
      // edge code none defines no event
      assign evt_hit[i] = cfg[tcwg_pkg::CFG_GEN] &
                          (((edg == tcwg_pkg::EDGE_RISE) & rise) |
                           ((edg == tcwg_pkg::EDGE_FALL) & fall) |
                           ((edg == tcwg_pkg::EDGE_BOTH) & (rise | fall)));
    end
  endgenerate

  // ==========================================
  // highest-priority nonzero action applied to a line
  function automatic logic act_pick(input logic cur, input logic [3:0][1:0] acts);
    logic [1:0] a;
    logic       v;
    a = 2'h0;
    // index 3 is the strongest: soft trigger, event, limit, match
    for (int n = 0; n < 4; n++) begin
      if (acts[n] != 2'h0) begin
        a = acts[n];
      end
    end
    unique case (a)
      tcwg_pkg::ACT_SET: v = 1'b1;
      tcwg_pkg::ACT_CLR: v = 1'b0;
      tcwg_pkg::ACT_TOG: v = ~cur;
      default:           v = cur;
    endcase
    return v;
  endfunction

  // ==========================================
  // next state
  always_comb begin
    logic [31:0] cfg;   // channel config
    logic        gen;   // generation mode
    logic [1:0]  prof;  // effective count_profile
    logic        sel;   // write hits this channel
    logic        cmd;   // channel_command written
    logic        sw;    // soft or block trigger
    logic        ma;    // match a
    logic        mb;    // match b
    logic        mc;    // limit match
    logic        d;     // direction for this edge
    logic        sync;  // block trigger
    logic [15:0] top;   // up/down turning point
    logic [1:0]  rch;   // read window
    cfg  = 32'h0;
    gen  = 1'b0;
    prof = 2'h0;
    sel  = 1'b0;
    cmd  = 1'b0;
    sw   = 1'b0;
    ma   = 1'b0;
    mb   = 1'b0;
    mc   = 1'b0;
    d    = 1'b0;
    sync = 1'b0;
    top  = 16'h0;
    rch  = paddr[7:6];
    s_d  = s_q;
    // three-stage pin sync, change taken when stages 2 and 3 agree
    s_d.s1  = {line_b_in, line_a_in, ext_clock_pin};
    s_d.s2  = s_q.s1;
    s_d.s3  = s_q.s2;
    s_d.pin = ((s_q.s2 ~^ s_q.s3) & s_q.s3) | ((s_q.s2 ^ s_q.s3) & s_q.pin);
    s_d.pre      = s_q.pre + 10'h001;
    s_d.xc_prev  = xc;
    s_d.evt_prev = evt_src;
    // block registers
    if (wr && (paddr[7:0] == tcwg_pkg::OFF_BCFG)) begin
      s_d.bcfg = pwdata[tcwg_pkg::BCFG_W-1:0];
    end
    sync = wr && (paddr[7:0] == tcwg_pkg::OFF_BCMD) && pwdata[tcwg_pkg::BCMD_SYNC];
    for (int c = 0; c < 3; c++) begin
      cfg  = s_q.cfg[c];
      gen  = cfg[tcwg_pkg::CFG_GEN];
      prof = gen ? cfg[tcwg_pkg::CFG_PROF_LSB +: 2] : 2'h0;
      sel  = wr && (rch == 2'(c));
      cmd  = sel && (paddr[5:0] == tcwg_pkg::OFF_CMD);
      // register writes; reserved offsets fall through
      if (sel) begin
        unique case (paddr[5:0])
          tcwg_pkg::OFF_CFG:  s_d.cfg[c] = pwdata;
          tcwg_pkg::OFF_MA:   if (gen) s_d.ra[c] = pwdata[15:0];
          tcwg_pkg::OFF_MB:   if (gen) s_d.rb[c] = pwdata[15:0];
          tcwg_pkg::OFF_LIM:  s_d.rc[c] = pwdata[15:0];
          tcwg_pkg::OFF_IEN:  s_d.imask[c] = s_q.imask[c] | pwdata[tcwg_pkg::MASK_W-1:0];
          tcwg_pkg::OFF_IDIS: s_d.imask[c] = s_q.imask[c] & ~pwdata[tcwg_pkg::MASK_W-1:0];
          default:            s_d.cfg[c] = s_q.cfg[c];
        endcase
      end
      // clock on, unless off in the same write
      if (cmd && pwdata[tcwg_pkg::CMD_OFF]) begin
        s_d.clk_en[c]  = 1'b0;
        s_d.clk_run[c] = 1'b0;
      end else if (cmd && pwdata[tcwg_pkg::CMD_ON]) begin
        s_d.clk_en[c] = 1'b1;
      end
      // flags read clears only what was reported
      if (rd && (rch == 2'(c)) && (paddr[5:0] == tcwg_pkg::OFF_FLG)) begin
        s_d.wrap[c] = s_q.wrap[c] & ~s_q.rdata[tcwg_pkg::FLG_WRAP];
      end
      // counter clock edge: pending triggers and matches act here
      if (tick[c]) begin
        ma = gen && (s_q.cnt[c] == s_q.ra[c]);
        mb = gen && (s_q.cnt[c] == s_q.rb[c]);
        mc = gen && (s_q.cnt[c] == s_q.rc[c]);
        if (!prof[0]) begin
          // up profiles
          if (s_q.trig_pend[c] || (mc && prof[1])) begin
            s_d.cnt[c] = 16'h0;
          end else begin
            s_d.cnt[c] = s_q.cnt[c] + 16'h0001;
            if (s_q.cnt[c] == tcwg_pkg::CNT_TOP) begin
              s_d.wrap[c] = 1'b1;
            end
          end
        end else begin
          // up/down profiles, trigger reverses direction
          top = prof[1] ? s_q.rc[c] : tcwg_pkg::CNT_TOP;
          d   = s_q.dn[c] ^ s_q.trig_pend[c];
          if (!d && (s_q.cnt[c] == top)) begin
            d = 1'b1;
          end else if (d && (s_q.cnt[c] == 16'h0)) begin
            d = 1'b0;
          end
          s_d.dn[c]  = d;
          s_d.cnt[c] = d ? (s_q.cnt[c] - 16'h0001) : (s_q.cnt[c] + 16'h0001);
        end
        // limit match stops and disables independently
        if (mc && cfg[tcwg_pkg::CFG_LSTOP]) begin
          s_d.clk_run[c] = 1'b0;
        end
        if (mc && cfg[tcwg_pkg::CFG_LDIS]) begin
          s_d.clk_en[c]  = 1'b0;
          s_d.clk_run[c] = 1'b0;
        end
        // output control
        if (gen) begin
          s_d.line_a[c] = act_pick(s_q.line_a[c], {
            s_q.sw_pend[c]  ? cfg[tcwg_pkg::CFG_A_SW +: 2]  : 2'h0,
            s_q.evt_pend[c] ? cfg[tcwg_pkg::CFG_A_EVT +: 2] : 2'h0,
            mc              ? cfg[tcwg_pkg::CFG_A_LIM +: 2] : 2'h0,
            ma              ? cfg[tcwg_pkg::CFG_A_MA +: 2]  : 2'h0});
          if (cfg[tcwg_pkg::CFG_SRC_LSB +: 2] != 2'h0) begin
            s_d.line_b[c] = act_pick(s_q.line_b[c], {
              s_q.sw_pend[c] ? cfg[tcwg_pkg::CFG_B_SW +: 2] : 2'h0,
              (s_q.evt_pend[c] && cfg[tcwg_pkg::CFG_ETRG]) ? cfg[tcwg_pkg::CFG_B_EVT +: 2] : 2'h0,
              mc             ? cfg[tcwg_pkg::CFG_B_LIM +: 2] : 2'h0,
              mb             ? cfg[tcwg_pkg::CFG_B_MB +: 2]  : 2'h0});
          end
        end
        s_d.trig_pend[c] = 1'b0;
        s_d.sw_pend[c]   = 1'b0;
        s_d.evt_pend[c]  = 1'b0;
      end
      // new triggers start the clock and wait for the next edge
      sw = sync || (cmd && pwdata[tcwg_pkg::CMD_SOFT]);
      if ((sw || (evt_hit[c] && cfg[tcwg_pkg::CFG_ETRG])) && s_d.clk_en[c]) begin
        s_d.clk_run[c]   = 1'b1;
        s_d.trig_pend[c] = 1'b1;
      end
      // line actions only pend on a running clock, so none goes stale
      if (sw && s_d.clk_run[c]) begin
        s_d.sw_pend[c] = 1'b1;
      end
      // an event on a clock that stays stopped is dropped
      if (evt_hit[c] && s_d.clk_run[c]) begin
        s_d.evt_pend[c] = 1'b1;
      end
    end
    // read data latched in the setup cycle
    if (psel && !penable && !pwrite) begin
      s_d.rdata = 32'h0;
      if (rch == tcwg_pkg::BLK_WIN) begin
        if (paddr[7:0] == tcwg_pkg::OFF_BCFG) begin
          s_d.rdata = {26'h0, s_q.bcfg};
        end
      end else begin
        unique case (paddr[5:0])
          tcwg_pkg::OFF_CFG:   s_d.rdata = s_q.cfg[rch];
          tcwg_pkg::OFF_CNT:   s_d.rdata = {16'h0, s_q.cnt[rch]};
          tcwg_pkg::OFF_MA:    s_d.rdata = {16'h0, s_q.ra[rch]};
          tcwg_pkg::OFF_MB:    s_d.rdata = {16'h0, s_q.rb[rch]};
          tcwg_pkg::OFF_LIM:   s_d.rdata = {16'h0, s_q.rc[rch]};
          tcwg_pkg::OFF_FLG: begin
            s_d.rdata[tcwg_pkg::FLG_WRAP]  = s_q.wrap[rch];
            s_d.rdata[tcwg_pkg::FLG_CLKON] = s_q.clk_en[rch];
          end
          tcwg_pkg::OFF_IMASK: s_d.rdata = {24'h0, s_q.imask[rch]};
          default:             s_d.rdata = 32'h0;
        endcase
      end
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs
  assign prdata     = s_q.rdata;
  assign pready     = 1'b1;
  assign pslverr    = 1'b0;
  assign line_a_out = s_q.line_a;
  assign line_b_out = s_q.line_b;
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      line_a_oe_n[c] = ~s_q.cfg[c][tcwg_pkg::CFG_GEN];
      line_b_oe_n[c] = ~(s_q.cfg[c][tcwg_pkg::CFG_GEN] &
                         (s_q.cfg[c][tcwg_pkg::CFG_SRC_LSB +: 2] != 2'h0));
    end
  end

endmodule

// [sim/tcwg_assertions.sv]
// port checker for the timer waveform generator
`timescale 1ns/1ps
module tcwg_assertions #(
  parameter int ADDR_W = 8  // decoded address width
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [2:0]        line_a_oe_n,
  input wire logic [2:0]        line_b_oe_n
);
  // ==========================================
  // decode helpers
  logic rd_set;   // read setup cycle
  logic wr_cfg0;  // completed write to channel 0 config
  assign rd_set  = psel && !penable && !pwrite;
  assign wr_cfg0 = psel && penable && pwrite && paddr == 8'h04;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // bus and pin properties
  ready_no_err_a: assert property (psel && penable |-> pready && !pslverr) else $error("bus stall or error");
  oe_a_mode_a: assert property (wr_cfg0 |=> line_a_oe_n[0] == !$past(pwdata[15]))
    else $error("line a drive does not follow mode");
  oe_b_src_a: assert property (wr_cfg0 |=> line_b_oe_n[0] == !($past(pwdata[15]) && $past(pwdata[11:10]) != 2'h0))
    else $error("line b drive does not follow source");
  oe_hold_a: assert property (!$past(wr_cfg0) |-> $stable(line_a_oe_n[0]) && $stable(line_b_oe_n[0]))
    else $error("line drive changed without config write");
  rdata_hold_a: assert property (!$past(rd_set) |-> $stable(prdata)) else $error("read data moved");
  resv_zero_a: assert property (rd_set && paddr[5:0] inside {6'h08, 6'h0c} |=> prdata == 32'h0)
    else $error("reserved word not zero");
  top_resv_a: assert property (rd_set && paddr[5:0] == 6'h3c |=> prdata == 32'h0)
    else $error("reserved top word not zero");
  cnt_width_a: assert property (rd_set && paddr[5:0] == 6'h10 && paddr[7:6] != 2'h3 |=> prdata[31:16] == 16'h0)
    else $error("count wider than 16 bits");
  bcfg_width_a: assert property (rd_set && paddr == 8'hc4 |=> prdata[31:6] == 26'h0)
    else $error("block config upper bits set");
  // main scenarios reached
  cover property (wr_cfg0 ##1 !line_a_oe_n[0]);
  cover property (rd_set && paddr == 8'hfc);
  cover property (rd_set && paddr == 8'h10);
endmodule

// [sim/tcwg_pins_model.sv]
// pin side model: external clock pins and line levels
`timescale 1ns/1ps
module tcwg_pins_model (
  input  wire logic       pclk,
  input  wire logic       pulse_req,
  input  wire logic [2:0] line_a_out,
  input  wire logic [2:0] line_a_oe_n,
  input  wire logic [2:0] line_b_out,
  input  wire logic [2:0] line_b_oe_n,
  output logic      [2:0] ext_clock_pin,
  output logic      [2:0] line_a_in,
  output logic      [2:0] line_b_in
);
  logic [2:0] hi_cnt = 3'h0;  // cycles left of the pulse
  logic [2:0] churn  = 3'h5;  // pattern for released lines
  // pulse held 4 cycles, longer than the sampling period
  always @(posedge pclk) begin
    churn <= ~churn;
    if (pulse_req) begin
      hi_cnt <= 3'h4;
    end else if (hi_cnt != 3'h0) begin
      hi_cnt <= hi_cnt - 3'h1;
    end
  end
  // pins stand still low between pulses
  assign ext_clock_pin = {2'b00, hi_cnt != 3'h0};
  // wire level: design value while driven, churn when released
  assign line_a_in = (~line_a_oe_n & line_a_out) | (line_a_oe_n & churn);
  assign line_b_in = (~line_b_oe_n & line_b_out) | (line_b_oe_n & churn);
endmodule

// [sim/tcwg_top_tb.sv]
// self-checking bench for the timer waveform generator
`timescale 1ns/1ps
module tcwg_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pulse_req, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  ext_clock_pin, line_a_in, line_a_out, line_a_oe_n, line_b_in, line_b_out, line_b_oe_n;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  localparam logic [7:0]  RST_OFF [12] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h2c, 8'h44, 8'h84,
                                          8'hc4, 8'h08, 8'hfc};
  localparam logic [31:0] EV_CFG [3] = '{32'h0030_9500, 32'h0030_8500, 32'h0030_9400};
  tcwg_top tcwg_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_clock_pin, .line_a_in, .line_a_out, .line_a_oe_n, .line_b_in, .line_b_out, .line_b_oe_n);
  tcwg_pins_model tcwg_pins_model_inst (.pclk, .pulse_req, .line_a_out, .line_a_oe_n, .line_b_out,
    .line_b_oe_n, .ext_clock_pin, .line_a_in, .line_b_in);
  // ==========================================
  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  // ==========================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // ==========================================
  // scenarios
  task automatic s_reset;
    chk("drive enables", 32'h3f, {26'h0, line_a_oe_n, line_b_oe_n});
    foreach (RST_OFF[i]) rdchk(RST_OFF[i], 32'h0, "reset word");
  endtask
  task automatic s_regs;
    apb(1'b1, 8'h14, 32'h1234);
    rdchk(8'h14, 32'h0, "match_a in capture");
    apb(1'b1, 8'h04, 32'h8000);
    apb(1'b1, 8'h14, 32'h1234);
    rdchk(8'h14, 32'h1234, "match_a in generation");
    apb(1'b1, 8'h08, 32'h55);
    rdchk(8'h08, 32'h0, "reserved word");
    apb(1'b1, 8'hc4, 32'h38);
    rdchk(8'hc4, 32'h38, "block_config");
    apb(1'b1, 8'h5c, 32'h77);
    rdchk(8'h5c, 32'h77, "limit ch1");
    rdchk(8'h1c, 32'h0, "limit ch0");
  endtask
  // count range per profile, limit 5
  task automatic s_profiles;
    logic [15:0] lo, hi;
    logic [1:0]  p;
    apb(1'b1, 8'h1c, 32'h5);
    for (int k = 0; k < 4; k++) begin
      p = 2'(k + 2);
      apb(1'b1, 8'h04, 32'h8000 | (32'(p) << 13));
      apb(1'b1, 8'h00, 32'h5);
      lo = 16'hffff;
      hi = 16'h0;
      // 3 and 4 cycle spacing in turn, so samples walk every count phase
      for (int j = 0; j < 40; j++) begin
        apb(1'b0, 8'h10, 32'h0);
        if (rd[15:0] < lo) lo = rd[15:0];
        if (rd[15:0] > hi) hi = rd[15:0];
        if (j % 2 == 1) @(posedge pclk);
      end
      if (p[1]) begin
        chk("limited top", 32'h5, 32'(hi));
        chk("limited bottom", 32'h0, 32'(lo));
      end else begin
        chk("free past limit", 32'h1, 32'(hi > 16'h5));
      end
    end
  endtask
  // stop keeps the clock enabled, disable drops it
  task automatic s_limit;
    logic [31:0] c;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 8'h04, 32'h8000 | (32'h40 << k));
      apb(1'b1, 8'h00, 32'h5);
      repeat (40) @(posedge pclk);
      apb(1'b0, 8'h10, 32'h0);
      c = rd;
      repeat (10) @(posedge pclk);
      rdchk(8'h10, c, "halted count");
      apb(1'b0, 8'h20, 32'h0);
      chk("clock enabled flag", 32'(k == 0), 32'(rd[16]));
    end
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b0, 8'h20, 32'h0);
    chk("on with off", 32'h0, 32'(rd[16]));
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk("on alone", 32'h1, 32'(rd[16]));
  endtask
  task automatic s_sync;
    apb(1'b1, 8'h44, 32'h8000);
    apb(1'b1, 8'h84, 32'h8000);
    apb(1'b1, 8'h40, 32'h1);
    apb(1'b1, 8'h80, 32'h1);
    apb(1'b1, 8'hc0, 32'h0);
    repeat (10) @(posedge pclk);
    rdchk(8'h50, 32'h0, "count before sync");
    apb(1'b1, 8'hc0, 32'h1);
    repeat (10) @(posedge pclk);
    apb(1'b0, 8'h50, 32'h0);
    chk("ch1 started", 32'h1, 32'(rd[15:0] != 16'h0 && rd[15:0] < 16'h20));
    apb(1'b0, 8'h90, 32'h0);
    chk("ch2 started", 32'h1, 32'(rd[15:0] != 16'h0 && rd[15:0] < 16'h20));
  endtask
  // soft trigger actions: a set / b clear, then a clear / b toggle
  task automatic s_lines;
    apb(1'b1, 8'h44, 32'h8040_8400);
    apb(1'b1, 8'h40, 32'h5);
    repeat (8) @(posedge pclk);
    chk("lines after set/clear", 32'h2, {30'h0, line_a_out[1], line_b_out[1]});
    chk("line b driven", 32'h0, 32'(line_b_oe_n[1]));
    apb(1'b1, 8'h44, 32'hc080_8400);
    apb(1'b1, 8'h40, 32'h4);
    repeat (8) @(posedge pclk);
    chk("lines after clear/toggle", 32'h1, {30'h0, line_a_out[1], line_b_out[1]});
  endtask
  // event on chained clock 0: trigger, event only, edge none
  task automatic s_event;
    logic [31:0] c;
    logic        la;
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 8'h04, EV_CFG[k]);
      apb(1'b1, 8'h00, 32'h5);
      repeat (60) @(posedge pclk);
      apb(1'b0, 8'h10, 32'h0);
      c = rd;
      la = line_a_out[0];
      pulse_req <= 1'b1;
      @(posedge pclk);
      pulse_req <= 1'b0;
      repeat (12) @(posedge pclk);
      apb(1'b0, 8'h10, 32'h0);
      chk("event restart", 32'(k == 0), 32'(rd[15:0] < c[15:0]));
      chk("event line a", 32'(k != 2), 32'(line_a_out[0] != la));
    end
  endtask
  task automatic close_out;
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pulse_req = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_regs();
    s_profiles();
    s_limit();
    s_sync();
    s_lines();
    s_event();
    close_out();
  end
endmodule
bind tcwg_top tcwg_assertions #(.ADDR_W(ADDR_W)) tcwg_assertions_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .line_a_oe_n, .line_b_oe_n);
